// >>> core/ioexp_pkg.sv
package ioexp_pkg;
	// register index within one port's group, as printed per port
	localparam logic [3:0] IDX_DIR      = 4'h0;
	localparam logic [3:0] IDX_POL      = 4'h1;
	localparam logic [3:0] IDX_IRQ_EN   = 4'h2;
	localparam logic [3:0] IDX_COMPARE_DEFAULT_VALUE   = 4'h3;
	localparam logic [3:0] IDX_SRC_SEL  = 4'h4;
	localparam logic [3:0] IDX_CONFIG   = 4'h5;
	localparam logic [3:0] IDX_PULLUP   = 4'h6;
	localparam logic [3:0] IDX_FLAG     = 4'h7;
	localparam logic [3:0] IDX_CAPTURE  = 4'h8;
	localparam logic [3:0] IDX_PINS     = 4'h9;
	localparam logic [3:0] IDX_LATCH    = 4'ha;
	localparam logic [3:0] IDX_LAST     = 4'ha;

	// highest address of the interleaved map
	localparam logic [7:0] BANK0_LAST   = 8'h15;

	// configuration field positions
	localparam int unsigned CFG_BANK     = 7;
	localparam int unsigned CFG_MIRROR   = 6;
	localparam int unsigned CFG_HOLD     = 5;
	localparam int unsigned CFG_SLEW_OFF = 4;
	localparam int unsigned CFG_PIN_ADDR = 3;
	localparam int unsigned CFG_OD       = 2;
	localparam int unsigned CFG_LEVEL    = 1;

	// values after reset
	localparam logic [7:0] RST_BYTE     = 8'h00;
	// synchroniser contents at reset: chip select idle high, all else low
	localparam logic [21:0] SYNC_IDLE   = 22'h200000;

	// fixed upper nibble of the serial opcode byte
	localparam logic [3:0] OPCODE_FIXED = 4'h4;
	localparam logic [2:0] BIT_LAST     = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OP   = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b011,
		ST_SKIP = 3'b100
	} spi_state_t;
endpackage

// >>> core/port_ioc.sv
`timescale 1ns/1ps
module port_ioc import ioexp_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] pin_now,
	input  wire logic [7:0] irq_en,
	input  wire logic [7:0] def_val,
	input  wire logic [7:0] src_sel,
	input  wire logic       clear_req,
	output logic            pending,
	output logic [7:0]      flag,
	output logic [7:0]      capture
);
	logic [7:0] prev_r, prev_nxt;
	logic [7:0] flag_r, flag_nxt;
	logic [7:0] cap_r, cap_nxt;
	logic       pend_r, pend_nxt;
	logic [7:0] change;
	logic       hit;

	// per-pin change detection and latching of the first event
	always_comb begin
		change   = irq_en & ((src_sel & (pin_now ^ def_val)) | (~src_sel & (pin_now ^ prev_r)));
		hit      = |change;
		prev_nxt = pin_now;
		pend_nxt = pend_r;
		flag_nxt = flag_r;
		cap_nxt  = cap_r;
		if (hit && (!pend_r || clear_req)) begin
			pend_nxt = 1'h1; // a new event beats a simultaneous clear
			flag_nxt = change;
			cap_nxt  = pin_now;
		end else if (clear_req) begin
			pend_nxt = 1'h0;
			flag_nxt = RST_BYTE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prev_r <= RST_BYTE;
			flag_r <= RST_BYTE;
			cap_r  <= RST_BYTE;
			pend_r <= 1'h0;
		end else begin
			prev_r <= prev_nxt;
			flag_r <= flag_nxt;
			cap_r  <= cap_nxt;
			pend_r <= pend_nxt;
		end
	end

	assign pending = pend_r;
	assign flag    = flag_r;
	assign capture = cap_r;

	a_enable_gate: assert property (@(posedge clk) disable iff (rst)
		$rose(pend_r) |-> ((flag_r & ~$past(irq_en)) == 8'h00))
		else $error("flag set on a disabled pin");
	a_default_cmp: assert property (@(posedge clk) disable iff (rst)
		(!pend_r && ((irq_en & src_sel & (pin_now ^ def_val)) != 8'h00)) |=> pend_r && capture == $past(pin_now))
		else $error("default mismatch not latched");
	a_prev_cmp: assert property (@(posedge clk) disable iff (rst)
		(!pend_r && ((irq_en & ~src_sel & (pin_now ^ prev_r)) != 8'h00)) |=> pend_r && flag_r != 8'h00)
		else $error("level change not latched");
	a_hold_pend: assert property (@(posedge clk) disable iff (rst)
		(pend_r && !clear_req) |=> pend_r [*2] or (pend_r ##1 $past(clear_req)))
		else $error("pending dropped without a read");
	a_clear_read: assert property (@(posedge clk) disable iff (rst)
		(pend_r && clear_req && !hit) |=> !pend_r && flag_r == 8'h00)
		else $error("read did not clear pending");
	a_prev_track: assert property (@(posedge clk) disable iff (rst)
		1'h1 |=> prev_r == $past(pin_now))
		else $error("previous level not resampled");
endmodule // port_ioc

// >>> core/ioexp_irq_cfg.sv
`timescale 1ns/1ps
module ioexp_irq_cfg import ioexp_pkg::*; #(
	parameter bit I2C_VARIANT = 1'b0
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic        mosi,
	output logic             miso_out,
	output logic             miso_oe_n,
	input  wire logic [2:0]  addr_pins,
	input  wire logic [15:0] pin_level,
	output logic             irq_out_a,
	output logic             irq_out_a_oe_n,
	output logic             irq_out_b,
	output logic             irq_out_b_oe_n,
	output logic             sda_slew_on
);
	localparam int unsigned SYNC_W = 22;

	// two-stage synchroniser for every pin input
	logic [SYNC_W-1:0] sync1_r, sync2_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_r <= SYNC_IDLE; // idle select, else a false frame follows reset
			sync2_r <= SYNC_IDLE;
		end else begin
			sync1_r <= {cs_n, sck, mosi, addr_pins, pin_level};
			sync2_r <= sync1_r;
		end
	end

	logic        cs_n_s, sck_s, mosi_s;
	logic [2:0]  addr_s;
	logic [15:0] pins_s;
	assign {cs_n_s, sck_s, mosi_s, addr_s, pins_s} = sync2_r;

	// serial engine and register state
	spi_state_t      st_r, st_nxt;
	logic [2:0]      bit_cnt_r, bit_cnt_nxt;
	logic [7:0]      shift_in_r, shift_in_nxt;
	logic [7:0]      shift_out_r, shift_out_nxt;
	logic [7:0]      ptr_r, ptr_nxt;
	logic            rd_r, rd_nxt;
	logic            sck_prev_r, miso_r, miso_nxt, miso_oe_n_r, miso_oe_n_nxt;
	logic [7:0]      cfg_r, cfg_nxt;
	logic [1:0][7:0] en_r, en_nxt, def_r, def_nxt, sel_r, sel_nxt;
	logic [1:0]      clr;
	logic [1:0]      pend;
	logic [1:0][7:0] flag, cap;

	logic       sck_rise, sck_fall, byte_done;
	logic [7:0] byte_in, ptr_adv, rd_addr, rd_data;
	logic [2:0] dev_addr;
	logic [5:0] rd_dec, wr_dec;

	// {valid, port, index} for an address under the given bank setting
	function automatic logic [5:0] decode(input logic [7:0] a, input logic bank);
		logic ok;
		ok = 1'h0;
		if (bank) begin
			ok = (a[7:5] == 3'h0) && (a[3:0] <= IDX_LAST);
			return {ok, a[4], a[3:0]};
		end
		ok = (a <= BANK0_LAST);
		return {ok, a[0], a[4:1]};
	endfunction

	always_comb begin
		sck_rise = sck_s & ~sck_prev_r;
		sck_fall = ~sck_s & sck_prev_r;
		byte_in  = {shift_in_r[6:0], mosi_s};
		byte_done = sck_rise && (bit_cnt_r == BIT_LAST);
		dev_addr = (I2C_VARIANT || cfg_r[CFG_PIN_ADDR]) ? addr_s : 3'h0;
		ptr_adv  = cfg_r[CFG_HOLD] ? ptr_r : ptr_r + 8'h01;
		rd_addr  = (st_r == ST_ADDR) ? byte_in : ptr_adv;
		// decode with the bank in force before this byte
		rd_dec   = decode(rd_addr, cfg_r[CFG_BANK]);
		wr_dec   = decode(ptr_r, cfg_r[CFG_BANK]);
		rd_data  = 8'h00; // unmapped and out-of-block registers read zero
		if (rd_dec[5]) begin
			case (rd_dec[3:0])
				IDX_IRQ_EN:  rd_data = en_r[rd_dec[4]];
				IDX_COMPARE_DEFAULT_VALUE:  rd_data = def_r[rd_dec[4]];
				IDX_SRC_SEL: rd_data = sel_r[rd_dec[4]];
				IDX_CONFIG:  rd_data = {cfg_r[7:1], 1'h0};
				IDX_FLAG:    rd_data = flag[rd_dec[4]];
				IDX_CAPTURE: rd_data = cap[rd_dec[4]];
				IDX_PINS:    rd_data = pins_s[rd_dec[4]*8 +: 8];
				default:     rd_data = 8'h00;
			endcase
		end
	end

	// frame sequencing, pointer, shifting and register writes
	always_comb begin
		st_nxt        = st_r;
		bit_cnt_nxt   = bit_cnt_r;
		shift_in_nxt  = shift_in_r;
		shift_out_nxt = shift_out_r;
		ptr_nxt       = ptr_r;
		rd_nxt        = rd_r;
		miso_nxt      = miso_r;
		miso_oe_n_nxt = 1'h1;
		cfg_nxt       = cfg_r;
		en_nxt        = en_r;
		def_nxt       = def_r;
		sel_nxt       = sel_r;
		clr           = 2'h0;
		if (cs_n_s) begin
			st_nxt      = ST_IDLE;
			bit_cnt_nxt = 3'h0;
		end else if (st_r == ST_IDLE) begin
			st_nxt      = ST_OP;
			bit_cnt_nxt = 3'h0;
		end else begin
			miso_oe_n_nxt = (st_r == ST_SKIP) || (st_r == ST_OP); // shared line stays free until addressed
			if (sck_rise && st_r != ST_SKIP) begin
				shift_in_nxt = byte_in;
				bit_cnt_nxt  = bit_cnt_r + 3'h1;
			end
			if (byte_done) begin
				case (st_r)
					ST_OP: begin
						if (byte_in[7:4] == OPCODE_FIXED && byte_in[3:1] == dev_addr) begin
							rd_nxt = byte_in[0];
							st_nxt = ST_ADDR;
						end else begin
							st_nxt = ST_SKIP;
						end
					end
					ST_ADDR: begin
						ptr_nxt = byte_in;
						st_nxt  = ST_DATA;
					end
					ST_DATA: begin
						ptr_nxt = ptr_adv;
						if (!rd_r && wr_dec[5]) begin
							case (wr_dec[3:0])
								IDX_IRQ_EN:  en_nxt[wr_dec[4]]  = byte_in;
								IDX_COMPARE_DEFAULT_VALUE:  def_nxt[wr_dec[4]] = byte_in;
								IDX_SRC_SEL: sel_nxt[wr_dec[4]] = byte_in;
								IDX_CONFIG:  cfg_nxt = {byte_in[7:1], 1'h0};
								default:     cfg_nxt = cfg_r;
							endcase
						end
					end
					default: st_nxt = st_r;
				endcase
				// load the next read byte; reading pins or capture clears
				if (rd_r && (st_r == ST_ADDR || st_r == ST_DATA)) begin
					shift_out_nxt = rd_data;
					if (rd_dec[5] && (rd_dec[3:0] == IDX_PINS || rd_dec[3:0] == IDX_CAPTURE)) begin
						clr[rd_dec[4]] = 1'h1;
					end
				end
			end
			// mode 0: shift out on the falling edge
			if (sck_fall && st_r == ST_DATA && rd_r) begin
				miso_nxt      = shift_out_r[7];
				shift_out_nxt = {shift_out_r[6:0], 1'h0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r        <= ST_IDLE;
			bit_cnt_r   <= 3'h0;
			shift_in_r  <= RST_BYTE;
			shift_out_r <= RST_BYTE;
			ptr_r       <= RST_BYTE;
			rd_r        <= 1'h0;
			sck_prev_r  <= 1'h0;
			miso_r      <= 1'h0;
			miso_oe_n_r <= 1'h1;
			cfg_r       <= RST_BYTE;
			en_r        <= '0;
			def_r       <= '0;
			sel_r       <= '0;
		end else begin
			st_r        <= st_nxt;
			bit_cnt_r   <= bit_cnt_nxt;
			shift_in_r  <= shift_in_nxt;
			shift_out_r <= shift_out_nxt;
			ptr_r       <= ptr_nxt;
			rd_r        <= rd_nxt;
			sck_prev_r  <= sck_s;
			miso_r      <= miso_nxt;
			miso_oe_n_r <= miso_oe_n_nxt;
			cfg_r       <= cfg_nxt;
			en_r        <= en_nxt;
			def_r       <= def_nxt;
			sel_r       <= sel_nxt;
		end
	end

	assign miso_out  = miso_r;
	assign miso_oe_n = miso_oe_n_r;

	// one change detector per port
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_port
			port_ioc u_port (
				.clk       (clk),
				.rst       (rst),
				.pin_now   (pins_s[g*8 +: 8]),
				.irq_en    (en_r[g]),
				.def_val   (def_r[g]),
				.src_sel   (sel_r[g]),
				.clear_req (clr[g]),
				.pending   (pend[g]),
				.flag      (flag[g]),
				.capture   (cap[g])
			);
		end
	endgenerate

	// interrupt routing and pad drive, registered so pads never glitch
	logic act_a_r, act_a_nxt, act_b_r, act_b_nxt;
	logic out_a_r, out_a_nxt, oe_a_n_r, oe_a_n_nxt;
	logic out_b_r, out_b_nxt, oe_b_n_r, oe_b_n_nxt;
	logic slew_r, slew_nxt;
	always_comb begin
		act_a_nxt = cfg_r[CFG_MIRROR] ? (pend[0] | pend[1]) : pend[0];
		act_b_nxt = cfg_r[CFG_MIRROR] ? (pend[0] | pend[1]) : pend[1];
		if (cfg_r[CFG_OD]) begin
			out_a_nxt  = 1'h0;
			out_b_nxt  = 1'h0;
			oe_a_n_nxt = ~act_a_nxt;
			oe_b_n_nxt = ~act_b_nxt;
		end else begin
			out_a_nxt  = cfg_r[CFG_LEVEL] ? act_a_nxt : ~act_a_nxt;
			out_b_nxt  = cfg_r[CFG_LEVEL] ? act_b_nxt : ~act_b_nxt;
			oe_a_n_nxt = 1'h0;
			oe_b_n_nxt = 1'h0;
		end
		slew_nxt = ~cfg_r[CFG_SLEW_OFF];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			act_a_r  <= 1'h0;
			act_b_r  <= 1'h0;
			out_a_r  <= 1'h1;
			out_b_r  <= 1'h1;
			oe_a_n_r <= 1'h0;
			oe_b_n_r <= 1'h0;
			slew_r   <= 1'h1;
		end else begin
			act_a_r  <= act_a_nxt;
			act_b_r  <= act_b_nxt;
			out_a_r  <= out_a_nxt;
			out_b_r  <= out_b_nxt;
			oe_a_n_r <= oe_a_n_nxt;
			oe_b_n_r <= oe_b_n_nxt;
			slew_r   <= slew_nxt;
		end
	end

	assign irq_out_a      = out_a_r;
	assign irq_out_a_oe_n = oe_a_n_r;
	assign irq_out_b      = out_b_r;
	assign irq_out_b_oe_n = oe_b_n_r;
	assign sda_slew_on    = slew_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_mirror_or: assert property ($past(cfg_r[CFG_MIRROR]) |-> act_a_r == $past(|pend) && act_b_r == act_a_r)
		else $error("mirrored outputs disagree");
	a_separate_ports: assert property (!$past(cfg_r[CFG_MIRROR]) |->
		act_a_r == $past(pend[0]) && act_b_r == $past(pend[1]))
		else $error("unmirrored output follows wrong port");
	a_open_drain: assert property ($past(cfg_r[CFG_OD]) |->
		!irq_out_a && irq_out_a_oe_n == !act_a_r && irq_out_b_oe_n == !act_b_r)
		else $error("open-drain drive wrong");
	a_push_level: assert property (!$past(cfg_r[CFG_OD]) |-> !irq_out_a_oe_n &&
		irq_out_a == ($past(cfg_r[CFG_LEVEL]) ? act_a_r : !act_a_r))
		else $error("push-pull level wrong");
	a_slew_ctrl: assert property (1'h1 |=> sda_slew_on == !$past(cfg_r[CFG_SLEW_OFF]))
		else $error("slew control wrong");
	a_cfg_bit0: assert property (cfg_r[0] == 1'h0)
		else $error("config bit 0 stored");
	a_ptr_hold: assert property ((byte_done && st_r == ST_DATA && !cs_n_s) |=>
		ptr_r == ($past(cfg_r[CFG_HOLD]) ? $past(ptr_r) : $past(ptr_r) + 8'h01))
		else $error("pointer step wrong");
	a_addr_match: assert property ((byte_done && st_r == ST_OP && !cs_n_s && byte_in[3:1] != dev_addr) |=>
		st_r == ST_SKIP)
		else $error("foreign address accepted");
	c_mirror_irq: cover property (cfg_r[CFG_MIRROR] && act_a_r && act_b_r);
	c_read_clear: cover property (clr != 2'h0);
	c_skip_frame: cover property (st_r == ST_SKIP);
	c_bank_write: cover property ($rose(cfg_r[CFG_BANK]));
endmodule // ioexp_irq_cfg

// >>> testbench/spi_host_model.sv
`timescale 1ns/1ps
// mode 0 serial host; sck rests low and only runs inside frames
module spi_host_model (
	input  wire logic clk,
	output logic      cs_n,
	output logic      sck,
	output logic      mosi,
	input  wire logic miso_out,
	input  wire logic miso_oe_n
);
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		mosi = 1'b0;
	end

	// one frame: opcode, address, n data bytes msb first; 4 clk per sck half
	// whole bytes only
	task automatic frame(input logic [7:0] op, input logic [7:0] addr, input int n,
			input logic [31:0] wd, output logic [31:0] rdat, output logic drv);
		logic [47:0] sh;
		int          i;
		sh   = {op, addr, wd};
		rdat = '0;
		drv  = 1'b0;
		@(negedge clk) cs_n = 1'b0;
		repeat (4) @(negedge clk);
		for (i = 0; i < 16 + 8 * n; i++) begin
			mosi = sh[47 - i];
			repeat (4) @(negedge clk);
			sck = 1'b1;
			repeat (4) @(negedge clk);
			// sample late in the high phase, well after the bit has settled
			if (i >= 16) begin
				// a released data line reads high through its pull-up
				rdat = {rdat[30:0], miso_oe_n ? 1'b1 : miso_out};
				drv  = drv | !miso_oe_n;
			end
			sck = 1'b0;
		end
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		// released data line does not keep its last value
		mosi = ~mosi;
		repeat (8) @(negedge clk);
	endtask
endmodule // spi_host_model

// >>> testbench/port_change_irq_config_test.sv
`timescale 1ns/1ps
module port_change_irq_config_test;
	import ioexp_pkg::*;
	logic        clk;
	logic        rst;
	logic        cs_n;
	logic        sck;
	logic        mosi;
	logic        miso_out;
	logic        miso_oe_n;
	logic [2:0]  addr_pins;
	logic [15:0] pin_level;
	logic        irq_out_a;
	logic        irq_out_a_oe_n;
	logic        irq_out_b;
	logic        irq_out_b_oe_n;
	logic        sda_slew_on;
	logic [31:0] rd_v;
	logic        drv_v;
	int          num_errors;
	int          check_count;
	int          cycles;
	int          i2c_on = 0;
	logic        i2c_oe_n;
	// pads resolved with an external pull-up
	wire         irq_a_w = irq_out_a_oe_n ? 1'b1 : irq_out_a;
	wire         irq_b_w = irq_out_b_oe_n ? 1'b1 : irq_out_b;

	ioexp_irq_cfg #(.I2C_VARIANT(1'b0)) dut_u (
		.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso_out(miso_out),
		.miso_oe_n(miso_oe_n), .addr_pins(addr_pins), .pin_level(pin_level),
		.irq_out_a(irq_out_a), .irq_out_a_oe_n(irq_out_a_oe_n), .irq_out_b(irq_out_b),
		.irq_out_b_oe_n(irq_out_b_oe_n), .sda_slew_on(sda_slew_on)
	);

	// second build with the pin address always in force, fed the same frames
	ioexp_irq_cfg #(.I2C_VARIANT(1'b1)) dut_i2c_u (
		.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso_out(),
		.miso_oe_n(i2c_oe_n), .addr_pins(addr_pins), .pin_level(pin_level),
		.irq_out_a(), .irq_out_a_oe_n(), .irq_out_b(), .irq_out_b_oe_n(), .sda_slew_on()
	);

	// cycles in which the second build drives its data line
	always @(posedge clk) begin
		if (i2c_oe_n === 1'b0)
			i2c_on++;
	end

	spi_host_model host_u (
		.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard: whole run needs about 11k cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			$display("BAD timeout expected done seen hang");
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	task automatic wr(input logic [2:0] hw, input logic [7:0] a, input int n, input logic [31:0] d);
		host_u.frame({4'h4, hw, 1'b0}, a, n, d, rd_v, drv_v);
	endtask

	task automatic chk_rd(input string nm, input logic [2:0] hw, input logic [7:0] a, input logic [7:0] e);
		host_u.frame({4'h4, hw, 1'b1}, a, 1, 32'h0, rd_v, drv_v);
		chk(nm, e, rd_v[7:0]);
	endtask

	task automatic pins(input int b, input logic v);
		@(negedge clk) pin_level[b] = v;
		repeat (10) @(negedge clk);
	endtask

	task automatic s_reset();
		int a;
		for (a = 8'h04; a <= 8'h0b; a++)
			chk_rd("reg reset", 3'h0, a[7:0], 8'h00);
		chk("irq a idle", 8'h1, {7'h0, irq_a_w});
		chk("irq a oe", 8'h0, {7'h0, irq_out_a_oe_n});
		chk("slew reset", 8'h1, {7'h0, sda_slew_on});
	endtask

	task automatic s_cfg();
		wr(3'h0, 8'h0a, 1, 32'h11000000);
		chk_rd("cfg bit0", 3'h0, 8'h0b, 8'h10);
		chk("slew off", 8'h0, {7'h0, sda_slew_on});
		wr(3'h0, 8'h0a, 1, 32'h0);
		chk("slew on", 8'h1, {7'h0, sda_slew_on});
	endtask

	// burst across interleaved registers, then pointer held
	task automatic s_seq();
		wr(3'h0, 8'h04, 4, 32'h81422418);
		chk_rd("en a", 3'h0, 8'h04, 8'h81);
		chk_rd("en b", 3'h0, 8'h05, 8'h42);
		chk_rd("def a", 3'h0, 8'h06, 8'h24);
		chk_rd("def b", 3'h0, 8'h07, 8'h18);
		wr(3'h0, 8'h0a, 1, 32'h20000000);
		wr(3'h0, 8'h04, 2, 32'h0ff00000);
		chk_rd("held a", 3'h0, 8'h04, 8'hf0);
		chk_rd("held b", 3'h0, 8'h05, 8'h42);
		wr(3'h0, 8'h0a, 1, 32'h0);
		wr(3'h0, 8'h04, 4, 32'h0);
	endtask

	// address pins at 101, honoured by the first build only when enabled, by the second build always
	task automatic s_hwaddr();
		int c0;
		c0 = i2c_on;
		wr(3'h5, 8'h04, 1, 32'h33000000);
		chk("i2c match", 8'h1, {7'h0, i2c_on != c0});
		c0 = i2c_on;
		chk_rd("pins off", 3'h0, 8'h04, 8'h00);
		chk("i2c refuse", 8'h0, {7'h0, i2c_on != c0});
		chk_rd("off drive", 3'h5, 8'h04, 8'hff);
		chk("off oe", 8'h0, {7'h0, drv_v});
		wr(3'h0, 8'h0a, 1, 32'h08000000);
		wr(3'h0, 8'h04, 1, 32'h55000000);
		chk_rd("hw0 refused", 3'h5, 8'h04, 8'h00);
		wr(3'h5, 8'h04, 1, 32'h33000000);
		chk_rd("pins on", 3'h5, 8'h04, 8'h33);
		chk("on oe", 8'h1, {7'h0, drv_v});
		wr(3'h5, 8'h04, 1, 32'h0);
		wr(3'h5, 8'h0a, 1, 32'h0);
	endtask

	task automatic s_default();
		wr(3'h0, 8'h06, 1, 32'h0);
		wr(3'h0, 8'h08, 1, 32'h03000000);
		wr(3'h0, 8'h04, 1, 32'h01000000);
		pins(1, 1'b1);
		chk("disabled pin", 8'h1, {7'h0, irq_a_w});
		pins(0, 1'b1);
		chk("default hit", 8'h0, {7'h0, irq_a_w});
		chk("b quiet", 8'h1, {7'h0, irq_b_w});
		pins(0, 1'b0);
		repeat (20) @(negedge clk);
		chk("held pending", 8'h0, {7'h0, irq_a_w});
		chk_rd("capture a", 3'h0, 8'h10, 8'h03);
		chk("cleared a", 8'h1, {7'h0, irq_a_w});
		wr(3'h0, 8'h04, 1, 32'h0);
	endtask

	task automatic s_prev();
		wr(3'h0, 8'h05, 1, 32'h02000000);
		pins(8, 1'b1);
		chk("disabled b", 8'h1, {7'h0, irq_b_w});
		pins(9, 1'b1);
		chk("change b", 8'h0, {7'h0, irq_b_w});
		chk("a quiet", 8'h1, {7'h0, irq_a_w});
		chk_rd("pins b", 3'h0, 8'h13, 8'h03);
		chk("cleared b", 8'h1, {7'h0, irq_b_w});
	endtask

	task automatic s_mirror();
		wr(3'h0, 8'h0a, 1, 32'h40000000);
		pins(9, 1'b0);
		chk("mirror a", 8'h0, {7'h0, irq_a_w});
		chk("mirror b", 8'h0, {7'h0, irq_b_w});
		wr(3'h0, 8'h0a, 1, 32'h42000000);
		chk("high a", 8'h1, {7'h0, irq_out_a});
		chk("high oe", 8'h0, {7'h0, irq_out_a_oe_n});
		wr(3'h0, 8'h0a, 1, 32'h46000000);
		chk("od active", 8'h0, {7'h0, irq_a_w});
		chk_rd("pins b 2", 3'h0, 8'h13, 8'h01);
		chk("od idle a", 8'h1, {7'h0, irq_out_a_oe_n});
		chk("od idle b", 8'h1, {7'h0, irq_out_b_oe_n});
	endtask

	// two-byte bank write: second byte lands on an invalid address
	task automatic s_bank();
		wr(3'h0, 8'h0a, 2, 32'h80550000);
		chk_rd("bank cfg a", 3'h0, 8'h05, 8'h80);
		chk_rd("bank cfg b", 3'h0, 8'h15, 8'h80);
		chk_rd("bank en b", 3'h0, 8'h12, 8'h02);
		wr(3'h0, 8'h05, 1, 32'h0);
		chk_rd("bank0 cfg", 3'h0, 8'h0a, 8'h00);
	endtask

	initial begin
		num_errors  = 0;
		check_count = 0;
		cycles      = 0;
		rst         = 1'b1;
		addr_pins   = 3'h5;
		pin_level   = 16'h0000;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		s_reset();
		s_cfg();
		s_seq();
		s_hwaddr();
		s_default();
		s_prev();
		s_mirror();
		s_bank();
		end_sim();
	end
endmodule // port_change_irq_config_test
